// *** ccp_ctrl.v ***
// Capture/compare/PWM mode control, capture path and bridge output steering.
`timescale 1ns/1ps
`include "ccp_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Mode 0000 turns off and resets; 0001,0011 reserved.
// - Capture on fall, rise, 4th or 16th rise.
// - Compare match toggles, sets or clears output; flags.
// - Mode 1010: match flags only, pin untouched.
// - Mode 1011: flag, reset timer, start conversion.
// - PWM modes; code bits invert output pairs.
// - Non-PWM: first pin is capture/compare, others port.
// - Steer 00: only first output modulated.
// - Steer 01 forward, 11 reverse full bridge.
// - Steer 10: half bridge with dead band.
// - Control bits 5:4 are duty low bits.
// - Steer bits 7:6, mode bits 3:0, reset zero.
// - Capture/compare use timer one, PWM timer two.
// - Capture copies 16-bit timer one count.
// - Capture sets flag; only software clears it.
// - New capture overwrites pair, no overrun flag.
// - Edge detector watches pin even when driven.
// - Prescaler clears when off or not capturing.
////////////////////////////////////////////////////////////////////////////////
module ccp_ctrl
(
	input  wire                   i_clk,               // System clock, 40 MHz.
	input  wire                   i_reset_n,           // Asynchronous reset, active low.
	input  wire [`CCP_ADDR_W-1:0] i_addr,              // Register address.
	input  wire [7:0]             i_wdata,             // Register write data.
	input  wire                   i_wr,                // Register write strobe.
	input  wire                   i_rd,                // Register read strobe.
	output reg  [7:0]             o_rdata,             // Read data, cycle after i_rd.
	input  wire [15:0]            i_timer_one_count,   // Timer one count.
	input  wire [9:0]             i_timer_two_count,   // Timer two 10-bit time base.
	input  wire                   i_timer_two_period,  // Timer two period match pulse.
	input  wire                   i_adc_enabled,       // Converter enabled level.
	input  wire                   i_capture_pin,       // Level seen on the capture pin.
	output reg  [3:0]             o_bridge_out,        // Pin levels, bit 0 is output a.
	output reg  [3:0]             o_bridge_oe,         // High where the block drives a pin.
	output reg                    o_ccp_event_flag,    // Capture/compare event flag.
	output reg                    o_timer_one_reset,   // Special event timer reset pulse.
	output reg                    o_adc_start          // Special event conversion start pulse.
);

////////////////////////////////////////////////////////////////////////////////
// Mode decoding helpers.

	function is_capture;
		input [3:0] mode;
		begin
			is_capture = (mode[3:2] == `CCP_GRP_CAPTURE);
		end
	endfunction

	function is_pwm;
		input [3:0] mode;
		begin
			is_pwm = (mode[3:2] == `CCP_GRP_PWM);
		end
	endfunction

	function is_compare;
		input [3:0] mode;
		begin
			is_compare = (mode == `CCP_MODE_CMP_TOG) || (mode == `CCP_MODE_CMP_SET) ||
				(mode == `CCP_MODE_CMP_CLR) || (mode == `CCP_MODE_CMP_SWI) ||
				(mode == `CCP_MODE_CMP_SPEV);
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers.

	reg  [7:0]  ctrl_r;
	reg  [7:0]  cap_lo_r;
	reg  [7:0]  cap_hi_r;
	reg  [6:0]  deadband_r;
	reg         flag_r;
	reg         pin_s1_r;
	reg         pin_s2_r;
	reg         pin_prev_r;
	reg  [3:0]  presc_r;
	reg         match_prev_r;
	reg         cmp_latch_r;
	reg  [9:0]  duty_lat_r;
	reg         pwm_r;
	reg         pwm_prev_r;
	reg  [6:0]  db_cnt_r;

	wire [1:0]  steer    = ctrl_r[`CCP_STEER_HI:`CCP_STEER_LO];
	wire [1:0]  duty_lsb = ctrl_r[`CCP_DUTY_HI:`CCP_DUTY_LO];
	wire [3:0]  mode     = ctrl_r[`CCP_MODE_HI:`CCP_MODE_LO];
	wire        wr_ctrl  = i_wr && (i_addr == `CCP_ADDR_CTRL);
	wire        wr_lo    = i_wr && (i_addr == `CCP_ADDR_CAP_LO);
	wire        wr_hi    = i_wr && (i_addr == `CCP_ADDR_CAP_HI);
	wire        wr_flag  = i_wr && (i_addr == `CCP_ADDR_FLAG);
	wire        wr_db    = i_wr && (i_addr == `CCP_ADDR_DEADBAND);

////////////////////////////////////////////////////////////////////////////////
// Capture edge detection and prescaler.

	// The pin is sampled whatever its direction, so a port write can capture.
	wire        rise = pin_s2_r && !pin_prev_r;
	wire        fall = !pin_s2_r && pin_prev_r;
	wire [3:0]  presc_inc = presc_r + 4'h1;
	reg         cap_event;

	always @*
	begin
		cap_event = 1'b0;
		case (mode)
			`CCP_MODE_CAP_FALL:   cap_event = fall;
			`CCP_MODE_CAP_RISE:   cap_event = rise;
			`CCP_MODE_CAP_RISE4:  cap_event = rise && (presc_r[1:0] == `CCP_PRESC_4_LAST);
			`CCP_MODE_CAP_RISE16: cap_event = rise && (presc_r == `CCP_PRESC_16_LAST);
			default:              cap_event = 1'b0;
		endcase
	end

////////////////////////////////////////////////////////////////////////////////
// Compare match detection against timer one.

	wire        match_lvl = is_compare(mode) &&
		(i_timer_one_count == {cap_hi_r, cap_lo_r});
	wire        match = match_lvl && !match_prev_r;
	wire        flag_set = cap_event || match;

////////////////////////////////////////////////////////////////////////////////
// Capture pair, compare latch and control registers.

	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ctrl_r       <= `CCP_CTRL_RESET;
			cap_lo_r     <= `CCP_CAP_RESET;
			cap_hi_r     <= `CCP_CAP_RESET;
			deadband_r   <= `CCP_DEADBAND_RESET;
			flag_r       <= 1'b0;
			pin_s1_r     <= 1'b0;
			pin_s2_r     <= 1'b0;
			pin_prev_r   <= 1'b0;
			presc_r      <= 4'h0;
			match_prev_r <= 1'b0;
			cmp_latch_r  <= 1'b0;
		end
		else
		begin
			pin_s1_r     <= i_capture_pin;
			pin_s2_r     <= pin_s1_r;
			pin_prev_r   <= pin_s2_r;
			match_prev_r <= match_lvl;
			if (wr_ctrl)
				ctrl_r <= i_wdata;
			if (wr_db)
				deadband_r <= i_wdata[6:0];
			// Prescaler keeps counting across prescaler changes.
			if (!is_capture(mode))
				presc_r <= 4'h0;
			else if (rise)
				presc_r <= presc_inc;
			// A capture always overwrites the pair and beats a software write.
			if (cap_event)
			begin
				cap_lo_r <= i_timer_one_count[7:0];
				cap_hi_r <= i_timer_one_count[15:8];
			end
			else
			begin
				if (wr_lo)
					cap_lo_r <= i_wdata;
				if (wr_hi && !is_pwm(mode))
					cap_hi_r <= i_wdata;
				else if (is_pwm(mode) && i_timer_two_period)
					cap_hi_r <= cap_lo_r;
			end
			// Hardware set wins over a software clear in the same cycle.
			if (flag_set)
				flag_r <= 1'b1;
			else if (wr_flag && !i_wdata[`CCP_FLAG_BIT])
				flag_r <= 1'b0;
			if (mode == `CCP_MODE_OFF)
				cmp_latch_r <= 1'b0;
			else if (match)
			begin
				case (mode)
					`CCP_MODE_CMP_TOG: cmp_latch_r <= !cmp_latch_r;
					`CCP_MODE_CMP_SET: cmp_latch_r <= 1'b1;
					`CCP_MODE_CMP_CLR: cmp_latch_r <= 1'b0;
					default:           cmp_latch_r <= cmp_latch_r;
				endcase
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// PWM generator on the timer two time base with dead band.

	wire [9:0]  duty_word = {cap_lo_r, duty_lsb};

	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			duty_lat_r <= 10'h000;
			pwm_r      <= 1'b0;
			pwm_prev_r <= 1'b0;
			db_cnt_r   <= 7'h00;
		end
		else if (!is_pwm(mode))
		begin
			duty_lat_r <= 10'h000;
			pwm_r      <= 1'b0;
			pwm_prev_r <= 1'b0;
			db_cnt_r   <= 7'h00;
		end
		else
		begin
			pwm_prev_r <= pwm_r;
			if (i_timer_two_period)
			begin
				duty_lat_r <= duty_word;
				pwm_r      <= (duty_word != 10'h000);
			end
			else if (i_timer_two_count == duty_lat_r)
				pwm_r <= 1'b0;
			if (pwm_r != pwm_prev_r)
				db_cnt_r <= deadband_r;
			else if (db_cnt_r != 7'h00)
				db_cnt_r <= db_cnt_r - 7'h01;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Output steering; act is the level before polarity, drv the enables.

	wire        db_idle = (db_cnt_r == 7'h00) && (pwm_r == pwm_prev_r);
	reg  [3:0]  act;
	reg  [3:0]  drv;

	always @*
	begin
		act = 4'h0;
		drv = 4'h0;
		if (is_pwm(mode))
		begin
			case (steer)
				`CCP_STEER_SINGLE:
				begin
					act = {3'h0, pwm_r};
					drv = 4'h1;
				end
				`CCP_STEER_FWD:
				begin
					act = {pwm_r, 2'h0, 1'b1};
					drv = 4'hF;
				end
				`CCP_STEER_HALF:
				begin
					act = {2'h0, !pwm_r && db_idle, pwm_r && db_idle};
					drv = 4'h3;
				end
				`CCP_STEER_REV:
				begin
					act = {2'h1, pwm_r, 1'b0};
					drv = 4'hF;
				end
				default:
				begin
					act = 4'h0;
					drv = 4'h0;
				end
			endcase
		end
		else
		begin
			// Only the first pin belongs to the block outside PWM.
			act = {3'h0, cmp_latch_r};
			drv = {3'h0, (mode == `CCP_MODE_CMP_TOG) || (mode == `CCP_MODE_CMP_SET) ||
				(mode == `CCP_MODE_CMP_CLR)};
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_pin
			// Outputs a and c follow mode bit 1, outputs b and d mode bit 0.
			wire inv = is_pwm(mode) && mode[(gi % 2 == 0) ? 1 : 0];
			always @(posedge i_clk or negedge i_reset_n)
			begin
				if (!i_reset_n)
				begin
					o_bridge_out[gi] <= 1'b0;
					o_bridge_oe[gi]  <= 1'b0;
				end
				else
				begin
					o_bridge_out[gi] <= act[gi] ^ inv;
					o_bridge_oe[gi]  <= drv[gi];
				end
			end
		end
	endgenerate

////////////////////////////////////////////////////////////////////////////////
// Special event pulses, flag output and register read port.

	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_timer_one_reset <= 1'b0;
			o_adc_start       <= 1'b0;
			o_ccp_event_flag  <= 1'b0;
			o_rdata           <= 8'h00;
		end
		else
		begin
			o_timer_one_reset <= match && (mode == `CCP_MODE_CMP_SPEV);
			o_adc_start       <= match && (mode == `CCP_MODE_CMP_SPEV) && i_adc_enabled;
			o_ccp_event_flag  <= flag_set || flag_r;
			o_rdata           <= 8'h00;
			if (i_rd)
			begin
				case (i_addr)
					`CCP_ADDR_CTRL:     o_rdata <= ctrl_r;
					`CCP_ADDR_CAP_LO:   o_rdata <= cap_lo_r;
					`CCP_ADDR_CAP_HI:   o_rdata <= cap_hi_r;
					`CCP_ADDR_FLAG:     o_rdata <= {7'h00, flag_r};
					`CCP_ADDR_DEADBAND: o_rdata <= {1'b0, deadband_r};
					default:            o_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule

// *** ccp_defines.vh ***
// Register map, field positions, mode codes and reset values of the capture/compare/PWM block.
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH

`define CCP_ADDR_W          3
`define CCP_ADDR_CTRL       3'h0
`define CCP_ADDR_CAP_LO     3'h1
`define CCP_ADDR_CAP_HI     3'h2
`define CCP_ADDR_FLAG       3'h3
`define CCP_ADDR_DEADBAND   3'h4

`define CCP_CTRL_RESET      8'h00
`define CCP_CAP_RESET       8'h00
`define CCP_DEADBAND_RESET  7'h00

`define CCP_STEER_HI        7
`define CCP_STEER_LO        6
`define CCP_DUTY_HI         5
`define CCP_DUTY_LO         4
`define CCP_MODE_HI         3
`define CCP_MODE_LO         0
`define CCP_FLAG_BIT        0

`define CCP_MODE_OFF        4'h0
`define CCP_MODE_RSVD_A     4'h1
`define CCP_MODE_CMP_TOG    4'h2
`define CCP_MODE_RSVD_B     4'h3
`define CCP_MODE_CAP_FALL   4'h4
`define CCP_MODE_CAP_RISE   4'h5
`define CCP_MODE_CAP_RISE4  4'h6
`define CCP_MODE_CAP_RISE16 4'h7
`define CCP_MODE_CMP_SET    4'h8
`define CCP_MODE_CMP_CLR    4'h9
`define CCP_MODE_CMP_SWI    4'hA
`define CCP_MODE_CMP_SPEV   4'hB

`define CCP_GRP_CAPTURE     2'h1
`define CCP_GRP_PWM         2'h3

`define CCP_STEER_SINGLE    2'h0
`define CCP_STEER_FWD       2'h1
`define CCP_STEER_HALF      2'h2
`define CCP_STEER_REV       2'h3

`define CCP_PRESC_4_LAST    2'h3
`define CCP_PRESC_16_LAST   4'hF

`endif

// *** ccp_far_model.sv ***
// Far-side model: timer one, timer two time base and the capture pin source.
`timescale 1ns/1ps
module ccp_far_model #(parameter [9:0] PER = 10'h020)
(
	input  wire        i_clk,     // Clock.
	input  wire        i_reset_n, // Reset, active low.
	input  wire        i_run,     // Timer one count enable.
	input  wire        i_clr,     // Timer one reset pulse.
	input  wire        i_pin,     // Level wanted on the pin.
	output reg  [15:0] o_t1,      // Timer one count.
	output reg  [9:0]  o_t2,      // Timer two time base.
	output wire        o_per,     // Timer two period pulse.
	output wire        o_pin      // Capture pin level.
);
assign o_per = o_t2 == PER - 10'h001;
assign o_pin = i_pin;
always @(posedge i_clk or negedge i_reset_n)
begin
	if (!i_reset_n)
	begin
		o_t1 <= 16'h0000;
		o_t2 <= 10'h000;
	end
	else
	begin
		o_t1 <= i_clr ? 16'h0000 : o_t1 + {15'h0000, i_run};
		o_t2 <= o_per ? 10'h000 : o_t2 + 10'h001;
	end
end
endmodule

// *** ccp_ctrl_props.sv ***
// Port checker of the capture/compare/PWM control block.
`timescale 1ns/1ps
`include "ccp_defines.vh"
module ccp_ctrl_props
(
	input wire                   i_clk,              // Clock.
	input wire                   i_reset_n,          // Reset.
	input wire [`CCP_ADDR_W-1:0] i_addr,             // Address.
	input wire [7:0]             i_wdata,            // Write data.
	input wire                   i_wr,               // Write strobe.
	input wire                   i_rd,               // Read strobe.
	input wire [7:0]             o_rdata,            // Read data.
	input wire [15:0]            i_timer_one_count,  // Timer one.
	input wire [9:0]             i_timer_two_count,  // Timer two.
	input wire                   i_timer_two_period, // Period pulse.
	input wire                   i_adc_enabled,      // Converter on.
	input wire                   i_capture_pin,      // Capture pin.
	input wire [3:0]             o_bridge_out,       // Pin levels.
	input wire [3:0]             o_bridge_oe,        // Pin drives.
	input wire                   o_ccp_event_flag,   // Event flag.
	input wire                   o_timer_one_reset,  // Timer reset.
	input wire                   o_adc_start         // Conversion start.
);
reg  [7:0] ctl_r;
reg  [1:0] age_r;
wire       ok  = age_r == 2'h3;
wire [3:0] md  = ctl_r[3:0];
wire [1:0] st  = ctl_r[7:6];
wire       pwm = ok && md[3:2] == `CCP_GRP_PWM;
wire       clr = i_wr && i_addr == `CCP_ADDR_FLAG && !i_wdata[0];
// Shadow of the control register and its age, so outputs are judged once settled.
always @(posedge i_clk or negedge i_reset_n)
begin
	if (!i_reset_n)
	begin
		ctl_r <= `CCP_CTRL_RESET;
		age_r <= 2'h0;
	end
	else if (i_wr && i_addr == `CCP_ADDR_CTRL)
	begin
		ctl_r <= i_wdata;
		age_r <= 2'h0;
	end
	else if (!ok)
		age_r <= age_r + 2'h1;
end
default clocking @(posedge i_clk); endclocking
default disable iff (!i_reset_n);
off_idle_a: assert property (ok && md == 4'h0 |-> o_bridge_oe == 4'h0 && !o_bridge_out[0])
	else $error("off mode still drives");
port_pins_a: assert property (ok && md[3:2] != 2'h3 |->
	o_bridge_oe == {3'h0, md == 4'h2 || md == 4'h8 || md == 4'h9}) else $error("pin drive");
steer_oe_a: assert property (pwm |-> o_bridge_oe == (st == 2'h0 ? 4'h1 :
	st == 2'h2 ? 4'h3 : 4'hF)) else $error("steering drive");
bridge_fwd_a: assert property (pwm && st == `CCP_STEER_FWD |-> o_bridge_out[0] == !md[1] &&
	o_bridge_out[1] == md[0] && o_bridge_out[2] == md[1]) else $error("forward levels");
bridge_rev_a: assert property (pwm && st == `CCP_STEER_REV |-> o_bridge_out[2] == !md[1] &&
	o_bridge_out[0] == md[1] && o_bridge_out[3] == md[0]) else $error("reverse levels");
half_dead_a: assert property (pwm && st == `CCP_STEER_HALF |->
	!((o_bridge_out[0] ^ md[1]) && (o_bridge_out[1] ^ md[0]))) else $error("both active");
spev_pulse_a: assert property (o_timer_one_reset |-> md == 4'hB && o_ccp_event_flag
	##1 !o_timer_one_reset) else $error("special event pulse");
adc_gate_a: assert property (o_adc_start |-> o_timer_one_reset && $past(i_adc_enabled))
	else $error("conversion start");
flag_hold_a: assert property (o_ccp_event_flag && !clr && !$past(clr) |=> o_ccp_event_flag)
	else $error("flag dropped");
cap_edge_a: assert property ($rose(o_ccp_event_flag) && ok && md[3:2] == 2'h1 |->
	$past(i_capture_pin, 3) != $past(i_capture_pin, 4) && $past(i_capture_pin, 3) == (md != 4'h4))
	else $error("capture without edge");
rd_ctrl_a: assert property ($past(i_rd) && $past(i_addr) == `CCP_ADDR_CTRL |->
	o_rdata == $past(ctl_r)) else $error("control read");
cap_seen_c: cover property ($rose(o_ccp_event_flag) && md[3:2] == 2'h1);
spev_seen_c: cover property (o_timer_one_reset);
half_seen_c: cover property (pwm && st == `CCP_STEER_HALF && o_bridge_out[1]);
endmodule
bind ccp_ctrl ccp_ctrl_props u_ccp_ctrl_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_timer_one_count(i_timer_one_count), .i_timer_two_count(i_timer_two_count),
	.i_timer_two_period(i_timer_two_period), .i_adc_enabled(i_adc_enabled),
	.i_capture_pin(i_capture_pin), .o_bridge_out(o_bridge_out), .o_bridge_oe(o_bridge_oe),
	.o_ccp_event_flag(o_ccp_event_flag), .o_timer_one_reset(o_timer_one_reset),
	.o_adc_start(o_adc_start));

// *** ccp_ctrl_test.sv ***
// Self-checking bench of the capture/compare/PWM control block.
`timescale 1ns/1ps
`include "ccp_defines.vh"
module ccp_ctrl_test;
reg         i_clk = 1'b0;
reg         i_reset_n = 1'b0;
reg         wr = 1'b0;
reg         rd = 1'b0;
reg         run = 1'b1;
reg         pin = 1'b0;
reg         adc = 1'b1;
reg  [2:0]  addr = 3'h0;
reg  [7:0]  wd = 8'h00;
reg  [15:0] tv;
reg  [15:0] h [0:3];
wire [7:0]  rdat;
wire [15:0] t1;
wire [9:0]  t2;
wire [3:0]  bo;
wire [3:0]  boe;
wire        per, cpin, flag, t1r, adcs;
integer     mismatches = 0;
integer     total_checks = 0;
integer     nrst = 0;
integer     nadc = 0;
integer     i, k;
// Rows of control value and expected pin drives.
localparam [167:0] ROWS = {12'h000, 12'h010, 12'h021, 12'h030, 12'h050, 12'h081, 12'h091,
	12'h0A0, 12'h0B0, 12'h0C1, 12'h8C3, 12'h4CF, 12'hCCF, 12'hFFF};
localparam [55:0] CMPS = {8'h08, 8'h02, 8'h02, 8'h09, 8'h0A, 8'h0B, 8'h0B};
localparam [63:0] PWMS = {16'h020C, 16'h031C, 16'h000C, 16'h020F};
ccp_ctrl u_ccp_ctrl (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wd),
	.i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_timer_one_count(t1), .i_timer_two_count(t2),
	.i_timer_two_period(per), .i_adc_enabled(adc), .i_capture_pin(cpin), .o_bridge_out(bo),
	.o_bridge_oe(boe), .o_ccp_event_flag(flag), .o_timer_one_reset(t1r), .o_adc_start(adcs));
ccp_far_model u_ccp_far_model (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_run(run),
	.i_clr(t1r), .i_pin(pin), .o_t1(t1), .o_t2(t2), .o_per(per), .o_pin(cpin));
always #12.5 i_clk = ~i_clk;
always @(posedge i_clk)
begin
	if (t1r === 1'b1) nrst = nrst + 1;
	if (adcs === 1'b1) nadc = nadc + 1;
end
task stop_test;
begin
	if (mismatches == 0 && total_checks > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
end
endtask
task chk(input [79:0] nm, input [15:0] e, input [15:0] s);
begin
	total_checks = total_checks + 1;
	if (s !== e)
	begin
		mismatches = mismatches + 1;
		$display("[FAIL] %0s expected %h seen %h", nm, e, s);
	end
end
endtask
task wr_reg(input [2:0] a, input [7:0] d);
begin
	@(posedge i_clk);
	addr <= a;
	wd <= d;
	wr <= 1'b1;
	@(posedge i_clk);
	wr <= 1'b0;
end
endtask
task rd_chk(input [2:0] a, input [7:0] e, input [79:0] nm);
begin
	@(posedge i_clk);
	addr <= a;
	rd <= 1'b1;
	@(posedge i_clk);
	rd <= 1'b0;
	#1 chk(nm, {8'h00, e}, {8'h00, rdat});
end
endtask
task pulses(input integer n);
begin
	repeat (n)
	begin
		@(posedge i_clk) pin <= 1'b1;
		repeat (2) @(posedge i_clk);
		pin <= 1'b0;
		repeat (2) @(posedge i_clk);
	end
end
endtask
////////////////////////////////////////
initial
begin
	repeat (16) @(posedge i_clk);
	i_reset_n <= 1'b1;
	wr_reg(3'h5, 8'hFF);
	for (i = 0; i < 6; i = i + 1)
		rd_chk(i[2:0], 8'h00, "reset");
	for (i = 0; i < 14; i = i + 1)
	begin
		wr_reg(3'h0, ROWS[(13 - i) * 12 + 4 +: 8]);
		repeat (3) @(posedge i_clk);
		rd_chk(3'h0, ROWS[(13 - i) * 12 + 4 +: 8], "ctrl");
		chk("drive", {12'h000, ROWS[(13 - i) * 12 +: 4]}, {12'h000, boe});
	end
	// Leave PWM first, where the high byte of the pair is read-only.
	wr_reg(3'h0, 8'h00);
	for (k = 0; k < 7; k = k + 1)
	begin
		if (k == 6) adc <= 1'b0;
		wr_reg(3'h3, 8'h00);
		tv = t1 + 16'h0028;
		wr_reg(3'h1, tv[7:0]);
		wr_reg(3'h2, tv[15:8]);
		wr_reg(3'h0, CMPS[(6 - k) * 8 +: 8]);
		i = 0;
		while (flag !== 1'b1 && i < 200)
		begin
			@(posedge i_clk);
			i = i + 1;
		end
		if (i >= 200) mismatches = mismatches + 1;
		if (i >= 200) stop_test;
		repeat (3) @(posedge i_clk);
		if (k < 4) chk("cmp_pin", {15'h0000, k[0] == 1'b0}, {15'h0000, bo[0]});
		else chk("cmp_keep", 16'h0000, {15'h0000, bo[0]});
	end
	chk("spev", 16'h0002, nrst[15:0]);
	chk("adc", 16'h0001, nadc[15:0]);
	wr_reg(3'h0, 8'h00);
	wr_reg(3'h3, 8'h00);
	wr_reg(3'h0, 8'h05);
	@(posedge i_clk) run <= 1'b0;
	for (k = 0; k < 2; k = k + 1)
	begin
		pulses(1);
		chk("cap_flag", 16'h0001, {15'h0000, flag});
		rd_chk(3'h1, t1[7:0], "cap_lo");
		rd_chk(3'h2, t1[15:8], "cap_hi");
		@(posedge i_clk) run <= 1'b1;
		repeat (5) @(posedge i_clk);
		run <= 1'b0;
	end
	wr_reg(3'h3, 8'h01);
	rd_chk(3'h3, 8'h01, "flag_keep");
	wr_reg(3'h3, 8'h00);
	rd_chk(3'h3, 8'h00, "flag_clr");
	wr_reg(3'h0, 8'h04);
	@(posedge i_clk) pin <= 1'b1;
	repeat (5) @(posedge i_clk);
	chk("rise_4", 16'h0000, {15'h0000, flag});
	pin <= 1'b0;
	repeat (5) @(posedge i_clk);
	chk("fall_4", 16'h0001, {15'h0000, flag});
	for (k = 0; k < 2; k = k + 1)
	begin
		pulses(2);
		wr_reg(3'h0, 8'h00);
		wr_reg(3'h3, 8'h00);
		wr_reg(3'h0, k == 0 ? 8'h06 : 8'h07);
		pulses(k == 0 ? 3 : 15);
		chk("presc_no", 16'h0000, {15'h0000, flag});
		pulses(1);
		chk("presc_yes", 16'h0001, {15'h0000, flag});
	end
	// Two rises in the 16th-edge mode, then a switch that must keep the count.
	pulses(2);
	wr_reg(3'h3, 8'h00);
	wr_reg(3'h0, 8'h06);
	pulses(1);
	chk("keep_no", 16'h0000, {15'h0000, flag});
	pulses(1);
	chk("keep_yes", 16'h0001, {15'h0000, flag});
	wr_reg(3'h4, 8'h04);
	for (k = 0; k < 4; k = k + 1)
	begin
		wr_reg(3'h0, PWMS[(3 - k) * 16 +: 8]);
		wr_reg(3'h1, PWMS[(3 - k) * 16 + 8 +: 8]);
		repeat (70) @(posedge i_clk);
		h[k] = 16'h0000;
		repeat (32)
		begin
			@(posedge i_clk);
			#1 if (bo[0] === 1'b1) h[k] = h[k] + 16'h0001;
		end
	end
	chk("duty_step", 16'h0005, h[1] - h[0]);
	chk("duty_zero", 16'h0000, h[2]);
	chk("inverted", h[0], 16'h0020 - h[3]);
	wr_reg(3'h0, 8'h8C);
	repeat (80) @(posedge i_clk);
	wr_reg(3'h0, 8'h4D);
	repeat (80) @(posedge i_clk);
	stop_test;
end
endmodule
